// file: rtl/fsep_ctrl.v
// fsep_ctrl.v: command-level control of a serial nor flash: instruction
// decode, geometry-checked erase, protection freeze, bank address, errors
// assumes: apb master on pclk; spi pins sampled by pclk (sclk far slower)
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "fsep_defs.vh"
module fsep_ctrl #(
  parameter ADDR_W = 32
) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // spi pins
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_si,
  input wire spi_reset_n,
  input wire serial_io_three,
  // interrupt and status
  output reg irq,
  output reg busy
);
  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  wire [4:0] pin_s;
  // flops start at each pin's idle level, so no false edge follows reset
  fsep_sync #(
    .W(5),
    .RST(5'h0b)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({spi_sclk, spi_cs_n, spi_si, spi_reset_n, serial_io_three}),
    .q(pin_s)
  );
  wire sclk_s = pin_s[4];
  wire cs_n_s = pin_s[3];
  wire si_s = pin_s[2];
  wire rst_pin_s = pin_s[1];
  wire io3_s = pin_s[0];

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [11:0] ctrl_reg;
  reg [7:0] config_reg_one;
  reg [7:0] status_reg_two;
  reg [7:0] bank_reg;
  reg [3:0] irq_stat_reg;
  reg [3:0] irq_mask_reg;
  reg [ADDR_W-1:0] prot_lo_reg;
  reg [ADDR_W-1:0] prot_hi_reg;
  reg sclk_d_reg;
  reg cs_d_reg;
  reg [5:0] bit_cnt_reg;
  reg [39:0] shift_reg;
  reg [15:0] op_cnt_reg;
  reg erased_small_reg;
  reg [7:0] last_op_reg;
  reg [ADDR_W-1:0] last_lo_reg;
  reg [ADDR_W-1:0] last_hi_reg;
  reg hw_reset_d_reg;

  wire frozen = config_reg_one[`FSEP_CR1_FREEZE];
  wire uniform = status_reg_two[`FSEP_SR2_UNIFORM];
  wire sect256 = ctrl_reg[`FSEP_CTRL_SECT256];
  wire param_top = config_reg_one[`FSEP_CR1_PARAM_PLACE];
  // reset source: dedicated pin, or serial_io_three when strapped so
  wire hw_reset = ctrl_reg[`FSEP_CTRL_RESET_PIN] ? !io3_s : !rst_pin_s;

  // ****************************************************************
  // apb access
  // ****************************************************************
  wire wr = psel && penable && pwrite;
  wire rd_setup = psel && !penable && !pwrite;
  wire mapped = (paddr <= `FSEP_OFF_PROT_HI) && (paddr[1:0] == 2'b00);

  // ****************************************************************
  // spi command capture
  // ****************************************************************
  wire sclk_rise = sclk_s && !sclk_d_reg;
  wire cmd_end = cs_n_s && !cs_d_reg;
  // instruction is the first byte, address after it
  wire [39:0] op_shift = shift_reg >> (bit_cnt_reg - 6'd8);
  wire [7:0] opcode = op_shift[7:0];
  wire four_byte = (bit_cnt_reg == 6'd40);
  // bank register supplies upper bits for 24-bit commands
  wire [31:0] raw_addr = four_byte ? shift_reg[31:0] : {bank_reg, shift_reg[23:0]};
  wire [ADDR_W-1:0] cmd_addr = raw_addr[ADDR_W-1:0];

  function in_param;
    input [ADDR_W-1:0] a;
    input top;
    begin
      // sixteen 4-KB sectors at top or bottom
      if (top)
        in_param = (a >> (`FSEP_SMALL_BITS + 5'h04)) ==
          ({ADDR_W{1'b1}} >> (`FSEP_SMALL_BITS + 5'h04));
      else
        in_param = (a >> (`FSEP_SMALL_BITS + 5'h04)) == {ADDR_W{1'b0}};
    end
  endfunction

  function [ADDR_W-1:0] align_dn;
    input [ADDR_W-1:0] a;
    input [4:0] bits;
    begin
      align_dn = (a >> bits) << bits;
    end
  endfunction

  // decide erase or page span; span_ok low means refused
  reg [4:0] span_bits;
  reg span_ok;
  always @* begin
    span_bits = 5'd0;
    span_ok = 1'b0;
    case (opcode)
      `FSEP_OP_SE4K: begin
        // only parameter sectors, hybrid only
        span_bits = `FSEP_SMALL_BITS;
        span_ok = !uniform && in_param(cmd_addr, param_top);
      end
      `FSEP_OP_SE64K: begin
        if (uniform || sect256) begin
          // 256-KB erase replaces 64-KB erase
          span_bits = `FSEP_LARGE_BITS;
          span_ok = 1'b1;
        end else begin
          // on parameter region this clears the sixteen small sectors
          span_bits = `FSEP_MID_BITS;
          span_ok = 1'b1;
        end
      end
      `FSEP_OP_PP: begin
        // page of 512 or 256 bytes
        span_bits = status_reg_two[`FSEP_SR2_PAGE512] ? 5'd9 : 5'd8;
        span_ok = 1'b1;
      end
      default: begin
        span_bits = 5'd0;
        span_ok = 1'b0;
      end
    endcase
  end

  wire [ADDR_W-1:0] span_lo = align_dn(cmd_addr, span_bits);
  wire [ADDR_W-1:0] span_hi = span_lo + ((({{(ADDR_W-1){1'b0}}, 1'b1}) << span_bits) - 1'b1);
  wire hits_prot = (span_lo <= prot_hi_reg) && (span_hi >= prot_lo_reg);
  wire is_erase = (opcode == `FSEP_OP_SE4K) || (opcode == `FSEP_OP_SE64K);
  wire is_prog = (opcode == `FSEP_OP_PP);
  wire otp_blocked = (opcode == `FSEP_OP_OTP_PROG) && (frozen || ctrl_reg[`FSEP_CTRL_OTP_LOCK]);
  wire fail = ctrl_reg[`FSEP_CTRL_FAIL_INJ];
  // a frame that ends while an operation runs is dropped
  wire cmd_valid = cmd_end && (bit_cnt_reg >= 6'd8) && !busy;
  wire start_op = cmd_valid && (is_erase || is_prog) && span_ok && !hits_prot && !fail;
  // protected target or internal failure: error, nothing done
  wire err_op = cmd_valid && (((is_erase || is_prog) && (hits_prot || fail)) || otp_blocked);

  // ****************************************************************
  // main sequential logic
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `FSEP_CTRL_RST;
      config_reg_one <= `FSEP_CR1_RST;
      status_reg_two <= `FSEP_SR2_RST;
      bank_reg <= 8'h00;
      irq_stat_reg <= 4'h0;
      irq_mask_reg <= 4'h0;
      prot_lo_reg <= {ADDR_W{1'b1}};
      prot_hi_reg <= {ADDR_W{1'b0}};
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      bit_cnt_reg <= 6'd0;
      shift_reg <= 40'h0;
      op_cnt_reg <= 16'd0;
      busy <= 1'b0;
      erased_small_reg <= 1'b0;
      last_op_reg <= 8'h00;
      last_lo_reg <= {ADDR_W{1'b0}};
      last_hi_reg <= {ADDR_W{1'b0}};
      hw_reset_d_reg <= 1'b0;
      irq <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_d_reg <= cs_n_s;
      // onset of a pin reset raises its status bit once
      hw_reset_d_reg <= hw_reset;
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd_setup) begin
        case (paddr)
          `FSEP_OFF_CTRL: prdata <= {20'h0, ctrl_reg};
          `FSEP_OFF_CFG1: prdata <= {24'h0, config_reg_one};
          `FSEP_OFF_STAT2: prdata <= {24'h0, status_reg_two};
          `FSEP_OFF_BANK: prdata <= {24'h0, bank_reg};
          `FSEP_OFF_IRQ_STAT: prdata <= {28'h0, irq_stat_reg};
          `FSEP_OFF_IRQ_MASK: prdata <= {28'h0, irq_mask_reg};
          `FSEP_OFF_STATUS: prdata <= {15'h0, erased_small_reg, last_op_reg, 7'h0, busy};
          `FSEP_OFF_PROT_LO: prdata <= last_lo_reg;
          `FSEP_OFF_PROT_HI: prdata <= last_hi_reg;
          default: prdata <= 32'h0;
        endcase
      end
      // hardware reset returns volatile command state
      if (hw_reset) begin
        bit_cnt_reg <= 6'd0;
        busy <= 1'b0;
        op_cnt_reg <= 16'd0;
        bank_reg <= 8'h00;
      end else begin
        if (!cs_n_s && sclk_rise && (bit_cnt_reg != 6'd40)) begin
          shift_reg <= {shift_reg[38:0], si_s};
          bit_cnt_reg <= bit_cnt_reg + 6'd1;
        end
        if (cmd_end)
          bit_cnt_reg <= 6'd0;
        // legacy power-down code reaches the bank register, never sleeps
        // a 16-bit frame carries one data byte after the opcode
        if (cmd_valid && (opcode == `FSEP_OP_LEGACY_PD || opcode == `FSEP_OP_BANK_WR)
            && bit_cnt_reg == 6'd16)
          bank_reg <= shift_reg[7:0];
        // 8-KB erase code falls to default: no action
        if (start_op) begin
          busy <= 1'b1;
          op_cnt_reg <= `FSEP_OP_CYCLES;
          last_op_reg <= opcode;
          last_lo_reg <= span_lo;
          last_hi_reg <= span_hi;
          erased_small_reg <= (opcode == `FSEP_OP_SE4K) ||
            ((opcode == `FSEP_OP_SE64K) && !uniform && !sect256 && in_param(cmd_addr, param_top));
        end else if (busy) begin
          op_cnt_reg <= op_cnt_reg - 16'd1;
          if (op_cnt_reg == 16'd1)
            busy <= 1'b0;
        end
      end
      if (wr && paddr == `FSEP_OFF_CTRL) begin
        // block protect bits frozen
        ctrl_reg <= frozen ? {pwdata[11:5], ctrl_reg[4:2], pwdata[1:0]} : pwdata[11:0];
        // otp lock cannot be released while frozen
        if (frozen)
          ctrl_reg[`FSEP_CTRL_OTP_LOCK] <= ctrl_reg[`FSEP_CTRL_OTP_LOCK];
      end
      if (wr && paddr == `FSEP_OFF_CFG1) begin
        // freeze locks placement and origin bits and stays set
        config_reg_one <= pwdata[7:0];
        if (frozen) begin
          config_reg_one[`FSEP_CR1_FREEZE] <= 1'b1;
          config_reg_one[`FSEP_CR1_PARAM_PLACE] <= param_top;
          config_reg_one[`FSEP_CR1_PROT_ORIGIN] <= config_reg_one[`FSEP_CR1_PROT_ORIGIN];
        end
      end
      if (wr && paddr == `FSEP_OFF_STAT2)
        status_reg_two <= pwdata[7:0];
      if (wr && paddr == `FSEP_OFF_BANK)
        bank_reg <= pwdata[7:0];
      if (wr && paddr == `FSEP_OFF_IRQ_MASK)
        irq_mask_reg <= pwdata[3:0];
      if (wr && paddr == `FSEP_OFF_PROT_LO && !frozen)
        prot_lo_reg <= pwdata[ADDR_W-1:0];
      if (wr && paddr == `FSEP_OFF_PROT_HI && !frozen)
        prot_hi_reg <= pwdata[ADDR_W-1:0];
      // write one clears, a simultaneous event wins
      irq_stat_reg <= (irq_stat_reg & ~((wr && paddr == `FSEP_OFF_IRQ_STAT) ? pwdata[3:0] : 4'h0))
        | {hw_reset && !hw_reset_d_reg,
           err_op && !is_erase,
           err_op && is_erase,
           busy && op_cnt_reg == 16'd1};
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule
`default_nettype wire

// file: rtl/fsep_defs.vh
// fsep_defs.vh: constants for the flash sector erase / protect control block
// assumes: included by the design files of this block only
`ifndef FSEP_DEFS_VH
`define FSEP_DEFS_VH
// apb register byte offsets
`define FSEP_OFF_CTRL 12'h000
`define FSEP_OFF_CFG1 12'h004
`define FSEP_OFF_STAT2 12'h008
`define FSEP_OFF_BANK 12'h00c
`define FSEP_OFF_IRQ_STAT 12'h010
`define FSEP_OFF_IRQ_MASK 12'h014
`define FSEP_OFF_STATUS 12'h018
`define FSEP_OFF_PROT_LO 12'h01c
`define FSEP_OFF_PROT_HI 12'h020
// config_reg_one fields
`define FSEP_CR1_FREEZE 0
`define FSEP_CR1_PARAM_PLACE 2
`define FSEP_CR1_PROT_ORIGIN 5
// status_reg_two fields
`define FSEP_SR2_PAGE512 6
`define FSEP_SR2_UNIFORM 7
// ctrl register fields
`define FSEP_CTRL_BP_LO 2
`define FSEP_CTRL_BP_HI 4
`define FSEP_CTRL_SECT256 8
`define FSEP_CTRL_RESET_PIN 9
`define FSEP_CTRL_OTP_LOCK 10
`define FSEP_CTRL_FAIL_INJ 11
// irq status bits
`define FSEP_IRQ_DONE 0
`define FSEP_IRQ_ERASE_ERR 1
`define FSEP_IRQ_PROG_ERR 2
`define FSEP_IRQ_RESET 3
// reset values
`define FSEP_CR1_RST 8'h00
`define FSEP_SR2_RST 8'h00
`define FSEP_CTRL_RST 12'h000
// instruction codes
`define FSEP_OP_PP 8'h02
`define FSEP_OP_SE4K 8'h20
`define FSEP_OP_ERASE8K 8'h40
`define FSEP_OP_SE64K 8'hd8
`define FSEP_OP_BANK_WR 8'h17
`define FSEP_OP_LEGACY_PD 8'hb9
`define FSEP_OP_OTP_PROG 8'h42
// geometry, 4-KB = 12 address bits, 64-KB = 16, 256-KB = 18, 16 param sectors
`define FSEP_SMALL_BITS 5'h0c
`define FSEP_MID_BITS 5'h10
`define FSEP_LARGE_BITS 5'h12
`define FSEP_PARAM_COUNT 16
// busy time of a modelled embedded operation in pclk cycles
`define FSEP_OP_CYCLES 16'd64
`endif

// file: rtl/fsep_sync.v
// fsep_sync.v: two-flop synchroniser for pin inputs
// assumes: inputs arrive from outside the pclk domain
`timescale 1ns/1ps
`default_nettype none
module fsep_sync #(
  parameter W = 1,
  // value after reset, the idle level of each pin
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= RST;
      q <= RST;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// file: sim/fsep_host.sv
// fsep_host.sv: spi host model that sends whole commands
// assumes: the testbench calls send; sclk rests low between frames
`timescale 1ns/1ps
`default_nettype none
// ****
// spi host
// ****
module fsep_host (
  // spi pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_si
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end
  // 800 ns link clock, only inside a frame; opcode first, msb first
  task automatic send(input logic [39:0] v, input int n);
    spi_cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      spi_si <= v[i];
      #400 spi_sclk <= 1'b1;
      #400 spi_sclk <= 1'b0;
    end
    #400 spi_cs_n <= 1'b1;
    // released line shows no stale level
    spi_si <= ~spi_si;
  endtask
endmodule
`default_nettype wire

// file: sim/fsep_ctrl_monitor.sv
// fsep_ctrl_monitor.sv: port-level checks of the control block
// assumes: bound to fsep_ctrl, apb answered one cycle after setup
`timescale 1ns/1ps
`default_nettype none
// ****
// checker
// ****
module fsep_ctrl_monitor (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // spi and status
  input wire logic spi_cs_n,
  input wire logic busy,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] busy_cnt;
  // length of the current busy run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= 8'h00;
    end else begin
      busy_cnt <= busy ? busy_cnt + 8'h01 : 8'h00;
    end
  end
  property p_ready_setup; psel && !penable |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_ready_access; pready |-> psel && penable; endproperty
  property p_err_bad;
    pready && (paddr > 12'h020 || paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  property p_err_ok;
    pready && paddr <= 12'h020 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  property p_rdata_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  property p_busy_len; $fell(busy) |-> busy_cnt == 8'h40; endproperty
  property p_busy_start; $rose(busy) |-> spi_cs_n; endproperty
  a_ready_setup: assert property (p_ready_setup)
    else $error("no pready after setup");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (p_ready_access)
    else $error("pready outside access");
  a_err_bad: assert property (p_err_bad)
    else $error("unmapped access not refused");
  a_err_ok: assert property (p_err_ok)
    else $error("mapped access refused");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("prdata changed without read");
  a_busy_len: assert property (p_busy_len)
    else $error("busy run not 64 cycles");
  a_busy_start: assert property (p_busy_start)
    else $error("busy rose inside a frame");
  c_busy: cover property ($rose(busy));
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
endmodule
bind fsep_ctrl fsep_ctrl_monitor fsep_ctrl_monitor_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .spi_cs_n(spi_cs_n), .busy(busy), .irq(irq));
`default_nettype wire

// file: sim/testbench.sv
// testbench.sv: self-checking bench of the control block
// assumes: fsep_ctrl on apb, fsep_host as spi host
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, busy, er;
  logic spi_sclk, spi_cs_n, spi_si, spi_reset_n, serial_io_three;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int n_fail = 0;
  int num_checks = 0;
  fsep_ctrl fsep_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
    .spi_reset_n(spi_reset_n), .serial_io_three(serial_io_three), .irq(irq), .busy(busy));
  fsep_host fsep_host_i (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] e);
    num_checks++;
    if (seen !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", s, e, seen);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd & m, e);
  endtask
  // one command, then whether busy showed within the 80 cycles after it
  task automatic cmd(input logic [39:0] v, input int n, input logic eb);
    logic seen;
    seen = 1'b0;
    fsep_host_i.send(v, n);
    repeat (80) begin
      @(posedge pclk);
      seen |= busy;
    end
    chk("busy", 32'(seen), 32'(eb));
  endtask
  task automatic pin(input logic io3, input logic [31:0] e);
    if (io3) serial_io_three <= 1'b0;
    else spi_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    serial_io_three <= 1'b1;
    spi_reset_n <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc(12'h010, 32'h8, e);
    wr(12'h010, 32'hf);
  endtask
  initial begin
    #2000000;
    n_fail++;
    print_verdict();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    spi_reset_n = 1'b1;
    serial_io_three = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(12'h014, 32'hf);
    cmd({8'hd8, 24'h000000}, 32, 1'b1);
    rdc(12'h018, 32'h1ff00, 32'h1d800);
    rdc(12'h010, 32'h1, 32'h1);
    wr(12'h010, 32'hf);
    cmd({8'h20, 24'h00f000}, 32, 1'b1);
    cmd({8'h20, 24'h010000}, 32, 1'b0);
    cmd({8'h40, 24'h000000}, 32, 1'b0);
    cmd({8'hb9, 8'h05}, 16, 1'b0);
    rdc(12'h00c, 32'hff, 32'h05);
    cmd({8'hd8, 24'h010000}, 32, 1'b1);
    rdc(12'h01c, 32'hffffffff, 32'h05010000);
    wr(12'h01c, 32'h0);
    wr(12'h020, 32'hffffffff);
    cmd({8'hd8, 24'h000000}, 32, 1'b0);
    rdc(12'h010, 32'h2, 32'h2);
    chk("irq", 32'(irq), 32'h1);
    wr(12'h014, 32'h0);
    @(posedge pclk);
    chk("irq", 32'(irq), 32'h0);
    wr(12'h010, 32'hf);
    wr(12'h014, 32'hf);
    wr(12'h01c, 32'hffffffff);
    wr(12'h020, 32'h0);
    wr(12'h000, 32'h800);
    cmd({8'hd8, 24'h020000}, 32, 1'b0);
    rdc(12'h010, 32'h2, 32'h2);
    wr(12'h010, 32'hf);
    wr(12'h008, 32'h80);
    wr(12'h000, 32'h100);
    cmd({8'h20, 24'h000000}, 32, 1'b0);
    cmd({8'hd8, 24'h040000}, 32, 1'b1);
    rdc(12'h020, 32'hffffffff, 32'h0507ffff);
    wr(12'h008, 32'h0);
    wr(12'h000, 32'h0);
    pin(1'b1, 32'h0);
    wr(12'h000, 32'h200);
    pin(1'b1, 32'h8);
    rdc(12'h00c, 32'hff, 32'h0);
    wr(12'h000, 32'h0);
    pin(1'b0, 32'h8);
    wr(12'h008, 32'h40);
    cmd({8'h02, 24'h000300}, 32, 1'b1);
    rdc(12'h01c, 32'hffffffff, 32'h00000200);
    rdc(12'h020, 32'hffffffff, 32'h000003ff);
    wr(12'h008, 32'h0);
    cmd({8'h02, 24'h000300}, 32, 1'b1);
    rdc(12'h01c, 32'hffffffff, 32'h00000300);
    apb(1'b0, 12'h024, 32'h0);
    chk("pslverr", 32'(er), 32'h1);
    wr(12'h000, 32'h14);
    wr(12'h004, 32'h25);
    wr(12'h000, 32'h0);
    wr(12'h004, 32'h0);
    rdc(12'h000, 32'h1c, 32'h14);
    rdc(12'h004, 32'h25, 32'h25);
    cmd({8'h42, 24'h000000}, 32, 1'b0);
    rdc(12'h010, 32'h4, 32'h4);
    print_verdict();
  end
endmodule
`default_nettype wire
